// ---- hdl/field_cfg_regs.sv ----
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module field_cfg_regs
  import field_cfg_pkg::*;
#(
  parameter int ID_BYTES = field_cfg_pkg::ID_MAX_BYTES
) (
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     supply_por_in,
  input  wire logic                     chip_en_in,
  input  wire logic                     hsel_in,
  input  wire logic [31:0]              haddr_in,
  input  wire logic [1:0]               htrans_in,
  input  wire logic                     hwrite_in,
  input  wire logic [2:0]               hsize_in,
  input  wire logic [31:0]              hwdata_in,
  input  wire logic                     hready_in,
  output logic      [31:0]              hrdata_out,
  output logic                          hreadyout_out,
  output logic                          hresp_out,
  input  wire logic                     wakeup_comparator_in,
  input  wire logic                     collision_comparator_in,
  output logic                          clock_extract_off_out,
  output logic      [2:0]               collision_level_out,
  output logic      [2:0]               wakeup_level_out,
  output logic                          wakeup_detect_on_out,
  output logic                          extended_field_range_out,
  output logic                          sdd_enable_out,
  output logic      [3:0]               id_length_out,
  output logic      [8*ID_BYTES-1:0]    target_id_out,
  output logic                          irq_out
);
  import field_cfg_pkg::*;

  // Elaboration check: the store must take the longest identifier
  if (ID_BYTES < ID_MAX_BYTES) begin : g_id_bytes_check
    $error("ID_BYTES must hold a 10-byte identifier");
  end

  // ==========================================================================
  // Pin synchronisers (two stages, first stage read only by the second)
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  always_ff @(posedge clk_in) begin
    sync1_r <= {supply_por_in, chip_en_in, wakeup_comparator_in, collision_comparator_in};
    sync2_r <= sync1_r;
  end
  logic por_s;
  logic en_s;
  logic wake_cmp_s;
  logic coll_cmp_s;
  assign por_s      = sync2_r[3];
  assign en_s       = sync2_r[2];
  assign wake_cmp_s = sync2_r[1];
  assign coll_cmp_s = sync2_r[0];

  // Ordinary registers clear on POR while enable is low; the retained one on POR alone
  logic ord_clear;
  logic ret_clear;
  assign ord_clear = rst_in || (por_s && !en_s);
  assign ret_clear = rst_in || por_s;

  // ==========================================================================
  // AHB-Lite address phase capture
  logic        ph_valid_r,  ph_valid_nxt;
  logic        ph_write_r,  ph_write_nxt;
  logic [4:0]  ph_idx_r,    ph_idx_nxt;
  always_comb begin
    ph_valid_nxt = 1'b0;
    ph_write_nxt = ph_write_r;
    ph_idx_nxt   = ph_idx_r;
    if (hsel_in && hready_in && htrans_in[1]) begin
      ph_valid_nxt = (hsize_in == HSIZE_WORD) || 1'b1;
      ph_write_nxt = hwrite_in;
      ph_idx_nxt   = haddr_in[6:2];
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ph_valid_r <= 1'b0;
      ph_write_r <= 1'b0;
      ph_idx_r   <= 5'h00;
    end else begin
      ph_valid_r <= ph_valid_nxt;
      ph_write_r <= ph_write_nxt;
      ph_idx_r   <= ph_idx_nxt;
    end
  end
  logic wr_en;
  logic rd_en;
  assign wr_en = ph_valid_r && ph_write_r;
  assign rd_en = ph_valid_r && !ph_write_r;
  // Zero wait states, always OKAY
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  // ==========================================================================
  // Configuration registers
  logic [7:0] coll_r, coll_nxt;
  logic [7:0] wake_r, wake_nxt;
  always_comb begin
    coll_nxt = coll_r;
    wake_nxt = wake_r;
    if (wr_en && ph_idx_r == IDX_COLL_LEVEL) begin
      coll_nxt = hwdata_in[7:0];
    end
    if (wr_en && ph_idx_r == IDX_WAKEUP_SDD) begin
      wake_nxt = hwdata_in[7:0];
    end
  end
  always_ff @(posedge clk_in) begin
    if (ord_clear) begin
      coll_r <= REG_RESET;
    end else begin
      coll_r <= coll_nxt;
    end
  end
  // Retained register: enable low does not touch it
  always_ff @(posedge clk_in) begin
    if (ret_clear) begin
      wake_r <= REG_RESET;
    end else begin
      wake_r <= wake_nxt;
    end
  end

  // ==========================================================================
  // Identifier shift store: each write to the ID port appends one byte
  logic [8*ID_BYTES-1:0] id_r, id_nxt;
  logic [3:0]            idcnt_r, idcnt_nxt;
  logic [3:0]            want_len;
  logic                  id_done;
  always_comb begin
    case (wake_r[IDSIZE_LSB +: 2])
      IDSIZE_4:  want_len = IDLEN_4;
      IDSIZE_7:  want_len = IDLEN_7;
      IDSIZE_10: want_len = IDLEN_10;
      default:   want_len = IDLEN_4;
    endcase
  end
  always_comb begin
    id_nxt    = id_r;
    idcnt_nxt = idcnt_r;
    id_done   = 1'b0;
    if (wr_en && ph_idx_r == IDX_TARGET_ID) begin
      id_nxt = {id_r[8*ID_BYTES-9:0], hwdata_in[7:0]};
      if (idcnt_r + 4'h1 >= want_len) begin
        idcnt_nxt = 4'h0;
        id_done   = 1'b1;
      end else begin
        idcnt_nxt = idcnt_r + 4'h1;
      end
    end else if (wr_en && ph_idx_r == IDX_WAKEUP_SDD) begin
      idcnt_nxt = 4'h0;
    end
  end
  always_ff @(posedge clk_in) begin
    if (ord_clear) begin
      id_r    <= '0;
      idcnt_r <= 4'h0;
    end else begin
      id_r    <= id_nxt;
      idcnt_r <= idcnt_nxt;
    end
  end

  // ==========================================================================
  // Outputs to the RF front end and SDD engine
  logic wake_on;
  assign wake_on = (wake_r[2:0] != LEVEL_OFF);
  always_ff @(posedge clk_in) begin
    if (ord_clear) begin
      clock_extract_off_out <= 1'b0;
      collision_level_out   <= LEVEL_OFF;
      target_id_out         <= '0;
    end else begin
      clock_extract_off_out <= coll_r[CLKEX_DIS_BIT];
      collision_level_out   <= coll_r[2:0];
      target_id_out         <= id_r;
    end
  end
  always_ff @(posedge clk_in) begin
    if (ret_clear) begin
      wakeup_level_out         <= LEVEL_OFF;
      wakeup_detect_on_out     <= 1'b0;
      extended_field_range_out <= 1'b0;
      sdd_enable_out           <= 1'b0;
      id_length_out            <= IDLEN_4;
    end else begin
      wakeup_level_out         <= wake_r[2:0];
      wakeup_detect_on_out     <= wake_on;
      extended_field_range_out <= wake_r[EXT_RANGE_BIT];
      sdd_enable_out           <= wake_r[SDD_EN_BIT];
      id_length_out            <= want_len;
    end
  end

  // Live comparator view; wake comparator masked when detection off
  logic [7:0] tstat;
  always_comb begin
    tstat               = 8'h00;
    tstat[WAKE_CMP_BIT] = wake_cmp_s && wake_on;
    tstat[COLL_CMP_BIT] = coll_cmp_s;
  end

  // ==========================================================================
  // Interrupts: sticky status, set wins over clear
  logic [EV_N-1:0] ist_r, ist_nxt;
  logic [EV_N-1:0] ien_r, ien_nxt;
  logic [1:0]      cmp_d_r;
  logic [EV_N-1:0] ev;
  always_comb begin
    ev              = '0;
    ev[EV_WAKE]     = tstat[WAKE_CMP_BIT] && !cmp_d_r[1];
    ev[EV_COLL]     = tstat[COLL_CMP_BIT] && !cmp_d_r[0];
    ev[EV_ID_DONE]  = id_done;
    ev[EV_BAD_SIZE] = wr_en && ph_idx_r == IDX_WAKEUP_SDD && hwdata_in[7:6] == 2'h3;
    ist_nxt = ist_r;
    ien_nxt = ien_r;
    if (wr_en && ph_idx_r == IDX_IRQ_CLEAR) begin
      ist_nxt = ist_r & ~hwdata_in[EV_N-1:0];
    end
    if (wr_en && ph_idx_r == IDX_IRQ_ENABLE) begin
      ien_nxt = hwdata_in[EV_N-1:0];
    end
    ist_nxt = ist_nxt | ev;
  end
  always_ff @(posedge clk_in) begin
    if (ord_clear) begin
      ist_r   <= '0;
      ien_r   <= '0;
      cmp_d_r <= 2'h0;
      irq_out <= 1'b0;
    end else begin
      ist_r   <= ist_nxt;
      ien_r   <= ien_nxt;
      cmp_d_r <= {tstat[WAKE_CMP_BIT], tstat[COLL_CMP_BIT]};
      irq_out <= |(ist_nxt & ien_nxt);
    end
  end

  // ==========================================================================
  // Read data: registered in the address phase so it stands in the data phase
  logic [31:0] rdata_nxt;
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    case (haddr_in[6:2])
      IDX_COLL_LEVEL:    rdata_nxt[7:0] = coll_r;
      IDX_TARGET_ID:     rdata_nxt[7:0] = id_r[7:0];
      IDX_WAKEUP_SDD:    rdata_nxt[7:0] = wake_r;
      IDX_TARGET_STATUS: rdata_nxt[7:0] = tstat;
      IDX_IRQ_STATUS:    rdata_nxt[EV_N-1:0] = ist_nxt;
      IDX_IRQ_ENABLE:    rdata_nxt[EV_N-1:0] = ien_nxt;
      IDX_ID_LOADED:     rdata_nxt[3:0] = idcnt_nxt;
      default:           rdata_nxt = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (hsel_in && hready_in && htrans_in[1] && !hwrite_in) begin
      hrdata_out <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Checks
  a_coll_por_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    (por_s && !en_s) |=> coll_r == REG_RESET)
    else $error("collision level not cleared");
  a_wake_kept_en: assert property (@(posedge clk_in) disable iff (rst_in)
    (!por_s && !en_s && !(wr_en && ph_idx_r == IDX_WAKEUP_SDD)) |=> $stable(wake_r))
    else $error("wake-up register changed on enable low");
  a_clkex_follow: assert property (@(posedge clk_in) disable iff (ord_clear)
    ##1 clock_extract_off_out == $past(coll_r[CLKEX_DIS_BIT]))
    else $error("clock extractor off wrong");
  a_coll_level: assert property (@(posedge clk_in) disable iff (ord_clear)
    ##1 collision_level_out == $past(coll_r[2:0]))
    else $error("collision level wrong");
  // Status bits trail their pins by exactly the two synchroniser stages
  a_coll_status: assert property (@(posedge clk_in) disable iff (rst_in)
    tstat[COLL_CMP_BIT] == $past(collision_comparator_in, 2))
    else $error("collision status not live");
  a_wake_status: assert property (@(posedge clk_in) disable iff (rst_in)
    tstat[WAKE_CMP_BIT] == ($past(wakeup_comparator_in, 2) && wake_r[2:0] != LEVEL_OFF))
    else $error("wake status not live");
  a_wake_off: assert property (@(posedge clk_in) disable iff (rst_in)
    (wake_r[2:0] == LEVEL_OFF) |=> !wakeup_detect_on_out)
    else $error("wake detect not off");
  a_id_len_map: assert property (@(posedge clk_in) disable iff (ret_clear)
    wake_r[7:6] == IDSIZE_7 ##1 wake_r[7:6] == IDSIZE_7 |-> id_length_out == IDLEN_7)
    else $error("id length map wrong");
  a_sdd_enable: assert property (@(posedge clk_in) disable iff (ret_clear)
    ##1 sdd_enable_out == $past(wake_r[SDD_EN_BIT]))
    else $error("sdd enable wrong");
  a_ext_range: assert property (@(posedge clk_in) disable iff (ret_clear)
    ##1 extended_field_range_out == $past(wake_r[EXT_RANGE_BIT]))
    else $error("range bit wrong");
  a_spare_store: assert property (@(posedge clk_in) disable iff (ord_clear)
    (wr_en && ph_idx_r == IDX_COLL_LEVEL) |=> coll_r[6:3] == $past(hwdata_in[6:3]))
    else $error("spare bits not stored");
  a_id_shift: assert property (@(posedge clk_in) disable iff (ord_clear)
    (wr_en && ph_idx_r == IDX_TARGET_ID) |=> id_r[7:0] == $past(hwdata_in[7:0]))
    else $error("id byte not stored");
endmodule

// ---- hdl/field_cfg_pkg.sv ----
package field_cfg_pkg;
  // ==========================================================================
  // Register word indices (byte address divided by four)
  localparam int          ADDR_W             = 8;
  localparam int          ID_MAX_BYTES       = 10;
  localparam logic [4:0]  IDX_COLL_LEVEL     = 5'h16;
  localparam logic [4:0]  IDX_TARGET_ID      = 5'h17;
  localparam logic [4:0]  IDX_WAKEUP_SDD     = 5'h18;
  localparam logic [4:0]  IDX_TARGET_STATUS  = 5'h19;
  localparam logic [4:0]  IDX_IRQ_STATUS     = 5'h1C;
  localparam logic [4:0]  IDX_IRQ_ENABLE     = 5'h1D;
  localparam logic [4:0]  IDX_IRQ_CLEAR      = 5'h1E;
  localparam logic [4:0]  IDX_ID_LOADED      = 5'h1F;
  // ==========================================================================
  // Field positions and reset values
  localparam int          CLKEX_DIS_BIT      = 7;
  localparam int          SDD_EN_BIT         = 5;
  localparam int          EXT_RANGE_BIT      = 3;
  localparam int          WAKE_CMP_BIT       = 7;
  localparam int          COLL_CMP_BIT       = 6;
  localparam int          IDSIZE_LSB         = 6;
  localparam logic [7:0]  REG_RESET          = 8'h00;
  localparam logic [1:0]  IDSIZE_4           = 2'h0;
  localparam logic [1:0]  IDSIZE_7           = 2'h1;
  localparam logic [1:0]  IDSIZE_10          = 2'h2;
  localparam logic [3:0]  IDLEN_4            = 4'h4;
  localparam logic [3:0]  IDLEN_7            = 4'h7;
  localparam logic [3:0]  IDLEN_10           = 4'hA;
  localparam logic [2:0]  LEVEL_OFF          = 3'h0;
  // Interrupt event bits
  localparam int          EV_WAKE            = 0;
  localparam int          EV_COLL            = 1;
  localparam int          EV_ID_DONE         = 2;
  localparam int          EV_BAD_SIZE        = 3;
  localparam int          EV_N               = 4;
  // AHB encodings
  localparam logic [1:0]  HTRANS_NONSEQ      = 2'h2;
  localparam logic [2:0]  HSIZE_WORD         = 3'h2;
endpackage

// ---- sim/host_model.sv ----
`timescale 1ns/1ns
// ==========================================================================
// Host side: AHB-Lite single word master and the ID load procedure
module host_model
  import field_cfg_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        hready_in,
  input  wire logic [31:0] hrdata_in,
  output logic             hsel_out,
  output logic [31:0]      haddr_out,
  output logic [1:0]       htrans_out,
  output logic             hwrite_out,
  output logic [2:0]       hsize_out,
  output logic [31:0]      hwdata_out
);
  // Bus idle from time zero
  initial begin
    hsel_out = 1'b0;
    haddr_out = 32'h0;
    htrans_out = 2'h0;
    hwrite_out = 1'b0;
    hsize_out = HSIZE_WORD;
    hwdata_out = 32'h0;
  end

  // Address phase held until hready, then data phase held until hready
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel_out <= 1'b1;
    haddr_out <= a;
    htrans_out <= HTRANS_NONSEQ;
    hwrite_out <= wr;
    hsize_out <= HSIZE_WORD;
    @(posedge clk_in);
    while (hready_in !== 1'b1) @(posedge clk_in);
    htrans_out <= 2'h0;
    hwdata_out <= wd;
    @(posedge clk_in);
    while (hready_in !== 1'b1) @(posedge clk_in);
    rd = hrdata_in;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0, d);
  endtask

  // Size code first, then n bytes; the caller matches n to the code and keeps code 11 out
  task automatic load_id(input logic [1:0] sz, input logic [5:0] ctl,
                         input logic [7:0] base, input int n);
    wr({25'h0, IDX_WAKEUP_SDD, 2'h0}, {24'h0, sz, ctl});
    for (int i = 0; i < n; i++) begin
      wr({25'h0, IDX_TARGET_ID, 2'h0}, {24'h0, base + 8'(i)});
    end
  endtask
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  import field_cfg_pkg::*;
  localparam logic [31:0] A_COLL = {25'h0, IDX_COLL_LEVEL, 2'h0};
  localparam logic [31:0] A_WAKE = {25'h0, IDX_WAKEUP_SDD, 2'h0};
  localparam logic [31:0] A_TST  = {25'h0, IDX_TARGET_STATUS, 2'h0};
  localparam logic [31:0] A_IST  = {25'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [31:0] A_IEN  = {25'h0, IDX_IRQ_ENABLE, 2'h0};
  localparam logic [31:0] A_ICLR = {25'h0, IDX_IRQ_CLEAR, 2'h0};
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        por = 1'b0;
  logic        en = 1'b1;
  logic        wcmp = 1'b0;
  logic        ccmp = 1'b0;
  logic        hsel, hwrite, hready, hresp, clkex, wake_on, ext_rng, sdd_en, irq;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0]  htrans;
  logic [2:0]  hsize, coll_lvl, wake_lvl;
  logic [3:0]  id_len;
  logic [79:0] tid;
  int          error_cnt = 0;
  int          n_compared = 0;

  // ==========================================================================
  // Clock, host and device
  always #4 clk_in = ~clk_in;
  host_model host (.clk_in(clk_in), .hready_in(hready), .hrdata_in(hrdata),
    .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite),
    .hsize_out(hsize), .hwdata_out(hwdata));
  field_cfg_regs uut (.clk_in(clk_in), .rst_in(rst_in), .supply_por_in(por),
    .chip_en_in(en), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
    .wakeup_comparator_in(wcmp), .collision_comparator_in(ccmp),
    .clock_extract_off_out(clkex), .collision_level_out(coll_lvl),
    .wakeup_level_out(wake_lvl), .wakeup_detect_on_out(wake_on),
    .extended_field_range_out(ext_rng), .sdd_enable_out(sdd_en),
    .id_length_out(id_len), .target_id_out(tid), .irq_out(irq));

  // ==========================================================================
  // Compare and verdict
  task automatic chk_port(input string nm, input logic [79:0] e, input logic [79:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Masked register read compare
  task automatic rchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string nm);
    host.rd(a, rdv);
    chk_port(nm, {48'h0, e}, {48'h0, rdv & m});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Whole run needs about 180 cycles
  initial begin
    tick(20000);
    error_cnt++;
    close_out();
  end

  // ==========================================================================
  // Tests
  initial begin
    logic [79:0] e, m;
    int          n;
    tick(8);
    rst_in <= 1'b0;
    tick(1);
    rchk(A_COLL, 32'hFF, 32'h0, "coll reset");
    rchk(A_WAKE, 32'hFF, 32'h0, "wake reset");
    chk_port("id len reset", 80'h4, 80'(id_len));
    rchk(32'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
    chk_port("hresp", 80'h0, 80'(hresp));
    // Collision register: extractor bit, spare bits, threshold
    host.wr(A_COLL, 32'hFF);
    tick(2);
    rchk(A_COLL, 32'hFF, 32'hFF, "coll readback");
    chk_port("clkex off", 80'h1, 80'(clkex));
    chk_port("coll level", 80'h7, 80'(coll_lvl));
    host.wr(A_COLL, 32'h05);
    tick(2);
    chk_port("clkex on", 80'h0, 80'(clkex));
    chk_port("coll level", 80'h5, 80'(coll_lvl));
    // Every legal size, back to back bytes; bit 4 spare kept
    for (int s = 0; s < 3; s++) begin
      n = (s == 0) ? 4 : (s == 1) ? 7 : 10;
      host.load_id(s[1:0], 6'h39, 8'h10 * 8'(s + 1), n);
      tick(2);
      e = '0;
      for (int i = 0; i < n; i++) e = {e[71:0], 8'h10 * 8'(s + 1) + 8'(i)};
      m = (80'h1 << (8 * n)) - 80'h1;
      chk_port("target id", e & m, tid & m);
      chk_port("id len", 80'(n), 80'(id_len));
      chk_port("sdd en", 80'h1, 80'(sdd_en));
      chk_port("ext range", 80'h1, 80'(ext_rng));
      chk_port("wake level", 80'h1, 80'(wake_lvl));
      rchk(A_WAKE, 32'hFF, {24'h0, s[1:0], 6'h39}, "wake readback");
      rchk(A_IST, 32'h4, 32'h4, "id done event");
      host.wr(A_ICLR, 32'hF);
    end
    // Size code 11: event, interrupt raised then cleared
    host.wr(A_IEN, 32'hF);
    host.wr(A_WAKE, 32'hC1);
    tick(2);
    chk_port("id len bad", 80'h4, 80'(id_len));
    rchk(A_IST, 32'h8, 32'h8, "bad size event");
    chk_port("irq on", 80'h1, 80'(irq));
    host.wr(A_ICLR, 32'hF);
    tick(2);
    chk_port("irq off", 80'h0, 80'(irq));
    // Comparators shown live, wake masked when level is zero
    ccmp <= 1'b1;
    wcmp <= 1'b1;
    tick(5);
    rchk(A_TST, 32'hC0, 32'hC0, "cmp high");
    rchk(A_IST, 32'h3, 32'h3, "cmp events");
    chk_port("irq cmp", 80'h1, 80'(irq));
    ccmp <= 1'b0;
    tick(5);
    rchk(A_TST, 32'hC0, 32'h80, "coll low");
    host.wr(A_WAKE, 32'h00);
    tick(2);
    chk_port("wake off", 80'h0, 80'(wake_on));
    rchk(A_TST, 32'hC0, 32'h00, "wake masked");
    // Masked source: status set, line stays low
    host.wr(A_ICLR, 32'hF);
    host.wr(A_IEN, 32'h0);
    ccmp <= 1'b1;
    tick(5);
    rchk(A_IST, 32'h2, 32'h2, "masked event");
    chk_port("irq masked", 80'h0, 80'(irq));
    // Enable low keeps wake register; supply POR clears it
    host.wr(A_COLL, 32'h83);
    host.wr(A_WAKE, 32'h2A);
    en <= 1'b0;
    tick(5);
    rchk(A_WAKE, 32'hFF, 32'h2A, "wake en low");
    en <= 1'b1;
    por <= 1'b1;
    tick(4);
    por <= 1'b0;
    tick(4);
    rchk(A_WAKE, 32'hFF, 32'h00, "wake por");
    rchk(A_COLL, 32'hFF, 32'h83, "coll por en high");
    en <= 1'b0;
    tick(4);
    por <= 1'b1;
    tick(4);
    por <= 1'b0;
    tick(4);
    rchk(A_COLL, 32'hFF, 32'h00, "coll por en low");
    close_out();
  end
endmodule
